//--- include/ras_params.svh
// Constants for the return address stack: layout, offsets and reset values.
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH

// ---------------------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------------------
`define RAS_DEPTH 12
`define RAS_LAST_LEVEL 4'hb
`define RAS_PC_W 16

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define RAS_ADDR_W 4
`define RAS_STATUS_OFFSET 4'h0
`define RAS_OSF_BIT 7
`define RAS_LEVEL_MSB 3
`define RAS_LEVEL_RESET 4'h0
`define RAS_OSF_RESET 1'b0

`endif

//--- include/ras_pkg.sv
// Types shared by the return address stack files.
package ras_pkg;

    typedef logic [15:0] ras_pc_t;
    typedef logic [3:0] ras_level_t;

    typedef struct packed {
        logic call;
        logic irq_ack;
        logic plain_ret;
        logic irq_ret;
        ras_pc_t pc;
    } ras_op_s;

    typedef enum logic [2:0] {
        RAS_IDLE = 3'b001,
        RAS_PUSH = 3'b010,
        RAS_POP  = 3'b100
    } ras_op_e;

endpackage : ras_pkg

//--- rtl/ras_store.sv
// Storage array of twelve saved program-counter entries.
`timescale 1ns/1ns
`include "ras_params.svh"

module ras_store (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [3:0] wr_idx_in,
    input wire ras_pkg::ras_pc_t wr_data_in,
    input wire logic [3:0] rd_idx_in,
    output ras_pkg::ras_pc_t rd_data_out
);

    ras_pkg::ras_pc_t mem_ff [0:`RAS_DEPTH-1];
    ras_pkg::ras_pc_t nxt_mem [0:`RAS_DEPTH-1];

    always_comb
    begin
        for (int i = 0; i < `RAS_DEPTH; i++)
        begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr_en_in && (wr_idx_in <= `RAS_LAST_LEVEL))
        begin
            nxt_mem[wr_idx_in] = wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < `RAS_DEPTH; i++)
            begin
                mem_ff[i] <= 16'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < `RAS_DEPTH; i++)
            begin
                mem_ff[i] <= nxt_mem[i];
            end
        end
    end

    // Out-of-range index cannot occur; it reads zero for safety.
    assign rd_data_out = (rd_idx_in <= `RAS_LAST_LEVEL) ?
        mem_ff[rd_idx_in] : 16'h0000;

endmodule : ras_store

//--- rtl/return_address_stack.sv
// Return address stack with level pointer, overflow flag and status port.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "ras_params.svh"

// Overview of operation
// - Twelve entries hold only saved program counters, unreachable by software.
// - A four-bit level pointer in status bits 3..0 selects the active entry.
// - A call or an interrupt acknowledge pushes the PC and advances the pointer.
// - A plain or interrupt return reloads the PC from the stack and steps back.
// - Reset sets the level pointer to zero, the empty top position.
// - When full, interrupt requests stay pending but acknowledge is withheld.
// - A call on a full stack still pushes, losing the oldest saved value.
// - Status bit 7 is set by a call when full or a plain return when empty.
// - Stack operations never clear the overflow flag; only reset or a software write does.
// - Status bits 6..4 read as zero.
// - Calls from reset step 1..11, the twelfth wraps to 0, the next flags.
// - A set overflow flag stays set through any number of returns.
// - A plain return on empty goes 0 to 11 and flags, then keeps counting down.

module return_address_stack (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Sequencer side.
    input wire ras_pkg::ras_op_s op_in,
    input wire logic irq_pending_in,
    output logic irq_ack_allow_out,
    output ras_pkg::ras_pc_t ret_pc_out,
    output logic ret_pc_valid_out,
    // Register port.
    input wire logic [`RAS_ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic overflow_sticky_flag_out,
    output logic [3:0] stack_level_pointer_out
);

    // -----------------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------------
    function automatic logic [3:0] lvl_inc(input logic [3:0] v);
        lvl_inc = (v == `RAS_LAST_LEVEL) ? 4'h0 : 4'(v + 4'h1);
    endfunction : lvl_inc

    function automatic logic [3:0] lvl_dec(input logic [3:0] v);
        lvl_dec = (v == 4'h0) ? `RAS_LAST_LEVEL : 4'(v - 4'h1);
    endfunction : lvl_dec

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    logic [3:0] level_index_bits_ff;
    logic [3:0] nxt_level;
    logic [3:0] count_ff;
    logic [3:0] nxt_count;
    logic osf_ff;
    logic nxt_osf;
    ras_pkg::ras_pc_t ret_pc_ff;
    ras_pkg::ras_pc_t nxt_ret_pc;
    logic ret_valid_ff;
    logic nxt_ret_valid;
    logic ack_allow_ff;
    logic nxt_ack_allow;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    ras_pkg::ras_op_e op_kind;
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    ras_pkg::ras_pc_t rd_data;
    logic status_hit;

    // The true occupancy is tracked apart from the pointer, because the
    // pointer value 0 means both empty and twelve-deep once it has wrapped.
    assign full = (count_ff == 4'(`RAS_DEPTH));
    assign empty = (count_ff == 4'h0);
    assign push = op_in.call | op_in.irq_ack;
    assign pop = op_in.plain_ret | op_in.irq_ret;
    assign status_hit = (reg_addr_in == `RAS_STATUS_OFFSET);

    // -----------------------------------------------------------------------
    // Operation decode
    // -----------------------------------------------------------------------
    always_comb
    begin
        if (push)
        begin
            op_kind = ras_pkg::RAS_PUSH;
        end
        else if (pop)
        begin
            op_kind = ras_pkg::RAS_POP;
        end
        else
        begin
            op_kind = ras_pkg::RAS_IDLE;
        end
    end

    // The entry written on push is the slot at the current pointer, so a
    // push on a full stack lands on the oldest value and overwrites it.
    assign wr_idx = level_index_bits_ff;
    assign rd_idx = lvl_dec(level_index_bits_ff);

    ras_store u_store (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(op_kind == ras_pkg::RAS_PUSH),
        .wr_idx_in(wr_idx),
        .wr_data_in(op_in.pc),
        .rd_idx_in(rd_idx),
        .rd_data_out(rd_data)
    );

    // -----------------------------------------------------------------------
    // Pointer, occupancy and overflow flag
    // -----------------------------------------------------------------------
    always_comb
    begin
        nxt_level = level_index_bits_ff;
        nxt_count = count_ff;
        nxt_osf = osf_ff;
        nxt_ret_pc = ret_pc_ff;
        nxt_ret_valid = 1'b0;
        // Software write takes bit 7 only; level bits are read-only.
        if (reg_wr_in && status_hit)
        begin
            nxt_osf = reg_wdata_in[`RAS_OSF_BIT];
        end
        case (op_kind)
            ras_pkg::RAS_PUSH:
            begin
                nxt_level = lvl_inc(level_index_bits_ff);
                if (full)
                begin
                    // Set wins over a simultaneous software clear.
                    if (op_in.call)
                    begin
                        nxt_osf = 1'b1;
                    end
                end
                else
                begin
                    nxt_count = 4'(count_ff + 4'h1);
                end
            end
            ras_pkg::RAS_POP:
            begin
                nxt_level = lvl_dec(level_index_bits_ff);
                nxt_ret_pc = rd_data;
                nxt_ret_valid = 1'b1;
                if (empty)
                begin
                    if (op_in.plain_ret)
                    begin
                        nxt_osf = 1'b1;
                    end
                end
                else
                begin
                    nxt_count = 4'(count_ff - 4'h1);
                end
                // No branch here lowers the flag while returns run.
            end
            ras_pkg::RAS_IDLE:
            begin
                nxt_level = level_index_bits_ff;
            end
            default:
            begin
                nxt_level = level_index_bits_ff;
            end
        endcase
    end

    // Acknowledge is allowed from the occupancy after this cycle, so a
    // return in flight frees the slot before the held interrupt is taken.
    always_comb
    begin
        nxt_ack_allow = (nxt_count != 4'(`RAS_DEPTH));
        if (irq_pending_in && !nxt_ack_allow)
        begin
            nxt_ack_allow = 1'b0;
        end
    end

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_rd_in && status_hit)
        begin
            nxt_rdata = {osf_ff, 3'b000, level_index_bits_ff};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            level_index_bits_ff <= `RAS_LEVEL_RESET;
            count_ff <= 4'h0;
            osf_ff <= `RAS_OSF_RESET;
            ret_pc_ff <= 16'h0000;
            ret_valid_ff <= 1'b0;
            ack_allow_ff <= 1'b1;
            rdata_ff <= 8'h00;
        end
        else
        begin
            level_index_bits_ff <= nxt_level;
            count_ff <= nxt_count;
            osf_ff <= nxt_osf;
            ret_pc_ff <= nxt_ret_pc;
            ret_valid_ff <= nxt_ret_valid;
            ack_allow_ff <= nxt_ack_allow;
            rdata_ff <= nxt_rdata;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign irq_ack_allow_out = ack_allow_ff;
    assign ret_pc_out = ret_pc_ff;
    assign ret_pc_valid_out = ret_valid_ff;
    assign reg_rdata_out = rdata_ff;
    assign overflow_sticky_flag_out = osf_ff;
    assign stack_level_pointer_out = level_index_bits_ff;

endmodule : return_address_stack

//--- verif/ras_props.sv
// Port checker for the return address stack.
`timescale 1ns/1ns
module ras_props (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire ras_pkg::ras_op_s op_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic ret_pc_valid_out,
    input wire logic overflow_sticky_flag_out,
    input wire logic [3:0] stack_level_pointer_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] lvl;
    logic flg;
    assign lvl = stack_level_pointer_out;
    assign flg = overflow_sticky_flag_out;
    sequence s_push;
        op_in.call || op_in.irq_ack;
    endsequence
    sequence s_pop;
        (op_in.plain_ret || op_in.irq_ret) && !op_in.call && !op_in.irq_ack;
    endsequence
    push_step_a: assert property (s_push ##0 (lvl != 4'hb) |=>
        lvl == $past(lvl) + 4'h1) else $error("push step wrong");
    push_wrap_a: assert property (s_push ##0 (lvl == 4'hb) |=>
        lvl == 4'h0) else $error("push wrap wrong");
    pop_step_a: assert property (s_pop ##0 (lvl != 4'h0) |=>
        lvl == $past(lvl) - 4'h1) else $error("pop step wrong");
    pop_wrap_a: assert property (s_pop ##0 (lvl == 4'h0) |=>
        lvl == 4'hb) else $error("pop wrap wrong");
    pop_valid_a: assert property (s_pop |=> ret_pc_valid_out)
        else $error("pop without valid");
    flag_hold_a: assert property (flg && !reg_wr_in |=> flg)
        else $error("flag dropped by hardware");
    read_status_a: assert property (reg_rd_in && reg_addr_in == 4'h0 |=>
        reg_rdata_out == {$past(flg), 3'h0, $past(lvl)})
        else $error("status read wrong");
    spare_zero_a: assert property (reg_rdata_out[6:4] == 3'h0)
        else $error("spare bits not zero");
    level_ro_a: assert property (reg_wr_in && op_in[19:16] == 4'h0 |=>
        $stable(lvl)) else $error("level written");
endmodule : ras_props
bind return_address_stack ras_props chk (.ref_clk_in, .rst_n_in, .op_in,
    .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .ret_pc_valid_out,
    .overflow_sticky_flag_out, .stack_level_pointer_out);

//--- verif/ras_seq_model.sv
// Instruction sequencer model issuing calls, acknowledges and returns.
`timescale 1ns/1ns
module ras_seq_model (
    input wire logic ref_clk_in,
    input wire logic ack_allow_in,
    output ras_pkg::ras_op_s op_out
);
    initial op_out = '0;
    // Kind 0 call, 1 interrupt acknowledge, 2 return, 3 interrupt return.
    task issue(input int k, input ras_pkg::ras_pc_t pc);
        int n;
        n = 0;
        // A full stack holds the acknowledge off until a return frees it.
        while (k == 1 && ack_allow_in !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        @(posedge ref_clk_in);
        op_out <= {k == 0, k == 1, k == 2, k == 3, pc};
        @(posedge ref_clk_in);
        op_out <= '0;
        #1;
    endtask : issue
endmodule : ras_seq_model

//--- verif/tb.sv
// Self-checking testbench for the return address stack.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); \
    bad_count++; end end
module tb;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    ras_pkg::ras_op_s op;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic allow, valid, flag;
    ras_pkg::ras_pc_t ret_pc;
    logic [7:0] rdata, d;
    logic [3:0] lvl;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    return_address_stack dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .op_in(op), .irq_pending_in(1'b1), .irq_ack_allow_out(allow),
        .ret_pc_out(ret_pc), .ret_pc_valid_out(valid), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .overflow_sticky_flag_out(flag),
        .stack_level_pointer_out(lvl));
    ras_seq_model seq (.ref_clk_in(ref_clk_in), .ack_allow_in(allow),
        .op_out(op));
    task wrap_up;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            wrap_up;
        end
    end
    task reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
        #1;
    endtask : reg_wr
    task reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd
    task t_fill;
        for (int i = 1; i <= 13; i++)
        begin
            seq.issue(0, 16'h0100 + 16'(i));
            `CHK(lvl, 4'(i % 12))
            `CHK(flag, 1'(i == 13))
            if (i == 12)
                `CHK(allow, 1'b0)
        end
    endtask : t_fill
    task t_drain;
        seq.issue(2, 16'h0000);
        `CHK(ret_pc, 16'h010d)
        `CHK(valid, 1'b1)
        `CHK(flag, 1'b1)
        `CHK(allow, 1'b1)
        @(posedge ref_clk_in);
        #1;
        `CHK(valid, 1'b0)
        seq.issue(3, 16'h0000);
        `CHK(ret_pc, 16'h010c)
        seq.issue(1, 16'h0abc);
        `CHK(lvl, 4'h0)
        seq.issue(2, 16'h0000);
        `CHK(ret_pc, 16'h0abc)
    endtask : t_drain
    task t_clear;
        reg_wr(4'h0, 8'h0f);
        `CHK(flag, 1'b0)
        `CHK(lvl, 4'hb)
        reg_rd(4'h0, d);
        `CHK(d, 8'h0b)
        reg_rd(4'h5, d);
        `CHK(d, 8'h00)
    endtask : t_clear
    task t_under;
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        #1;
        `CHK({flag, lvl, allow}, 6'h01)
        for (int i = 11; i >= 0; i--)
        begin
            seq.issue(2, 16'h0000);
            `CHK({flag, lvl}, {1'b1, 4'(i)})
        end
    endtask : t_under
    initial
    begin
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        reg_rd(4'h0, d);
        `CHK(d, 8'h00)
        t_fill;
        t_drain;
        t_clear;
        t_under;
        wrap_up;
    end
endmodule : tb
